// file: gtc_consts.vh
// Constants of the general timer with clock selection and capture
`ifndef GTC_CONSTS_VH
`define GTC_CONSTS_VH
// Register offsets
`define GTC_OFF_CTRL 8'h00
`define GTC_OFF_SMCFG 8'h08
`define GTC_OFF_STATUS 8'h10
`define GTC_OFF_EVGEN 8'h14
`define GTC_OFF_CHCFG 8'h18
`define GTC_OFF_CHEN 8'h20
`define GTC_OFF_COUNT 8'h24
`define GTC_OFF_PRESCALE 8'h28
`define GTC_OFF_RELOAD 8'h2c
`define GTC_OFF_CMP0 8'h34
// Control fields
`define GTC_CTRL_EN 0
`define GTC_CTRL_DIR 4
`define GTC_CTRL_CMS_LO 5
`define GTC_CTRL_CMS_HI 6
// Slave mode config fields
`define GTC_SM_SMS_LO 0
`define GTC_SM_SMS_HI 2
`define GTC_SM_TS_LO 4
`define GTC_SM_TS_HI 6
`define GTC_SM_ETF_LO 8
`define GTC_SM_ETF_HI 11
`define GTC_SM_EXT_TRIGGER_DIVIDER_LO 12
`define GTC_SM_EXT_TRIGGER_DIVIDER_HI 13
`define GTC_SM_ECE 14
`define GTC_SM_ETP 15
// Slave mode codes
`define GTC_SMS_INT 3'h0
`define GTC_SMS_ENC1 3'h1
`define GTC_SMS_ENC2 3'h2
`define GTC_SMS_ENC3 3'h3
`define GTC_SMS_EXT1 3'h7
// Trigger source codes
`define GTC_TS_ED 3'h4
`define GTC_TS_FP1 3'h5
`define GTC_TS_FP2 3'h6
`define GTC_TS_EXT_TRIGGER_FILTERED 3'h7
// Event generation bits
`define GTC_EV_UG 0
`define GTC_EV_CC0 1
// Reset values
`define GTC_RST_RELOAD 16'hffff
`define GTC_RST_ZERO 16'h0000
`endif

// file: gtc_filter.v
// Digital input filter with edge outputs
`timescale 1ns/1ps
module gtc_filter (
  // Clock and reset
  input wire ref_clk,
  input wire reset,
  // Input and setting
  input wire sig_in,
  input wire [3:0] setting,
  // Filtered level and edges
  output reg level_ff,
  output reg rise_ff,
  output reg fall_ff
);
  reg [3:0] cnt_ff;
  reg [3:0] nxt_cnt;
  reg nxt_level;
  always @* begin
    nxt_cnt = 4'h0;
    nxt_level = level_ff;
    if (sig_in != level_ff) begin
      nxt_cnt = cnt_ff + 4'h1;
      // Change accepted after setting+1 stable samples
      if (cnt_ff >= setting) begin
        nxt_level = sig_in;
        nxt_cnt = 4'h0;
      end
    end
  end
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      cnt_ff <= 4'h0;
      level_ff <= 1'b0;
      rise_ff <= 1'b0;
      fall_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      level_ff <= nxt_level;
      rise_ff <= nxt_level & ~level_ff;
      fall_ff <= ~nxt_level & level_ff;
    end
  end
endmodule

// file: gtc_ccreg.v
// Compare/capture register pair: preload and shadow
`timescale 1ns/1ps
`include "gtc_consts.vh"
module gtc_ccreg (
  // Clock and reset
  input wire ref_clk,
  input wire reset,
  // Control
  input wire is_capture,
  input wire preload_en,
  input wire update,
  input wire sw_we,
  input wire [15:0] sw_wdata,
  input wire cap_evt,
  input wire [15:0] count,
  // Visible value
  output reg [15:0] preload_ff,
  output reg [15:0] shadow_ff
);
  reg cap_d_ff;
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      preload_ff <= `GTC_RST_ZERO;
      shadow_ff <= `GTC_RST_ZERO;
      cap_d_ff <= 1'b0;
    end else begin
      cap_d_ff <= cap_evt & is_capture;
      if (is_capture) begin
        if (cap_evt)
          shadow_ff <= count;
        if (cap_d_ff)
          preload_ff <= shadow_ff;
      end else begin
        if (sw_we)
          preload_ff <= sw_wdata;
        if (!preload_en || update)
          shadow_ff <= sw_we ? sw_wdata : preload_ff;
      end
    end
  end
endmodule

// file: gtc_timer.v
// General-purpose 16-bit timer core with clock selection and capture channels
//
// Added by the designer: the plain strobed port and the address map.
`timescale 1ns/1ps
`include "gtc_consts.vh"
module gtc_timer #(
  parameter NCH = 4
) (
  // Clock and reset
  input wire ref_clk,
  input wire reset,
  // Register port
  input wire [7:0] addr,
  input wire [15:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  output reg [15:0] rdata_ff,
  // External inputs
  input wire ext_trigger_pin,
  input wire [3:0] internal_trigger_in,
  // Channel pins, three signals each; oe low drives
  input wire [3:0] chan_pin_in,
  output reg [3:0] chan_pin_out_ff,
  output reg [3:0] chan_pin_oe_n_ff,
  // Outputs to other peripherals
  output reg trigger_output_ff,
  output reg update_evt_ff
);
  // none of repetition, dead-time, complementary or brake logic exists
  // ********************************************************
  // Registers
  // ********************************************************
  reg [15:0] ctrl_ff;
  reg [15:0] smcfg_ff;
  reg [15:0] chcfg_ff [0:3];
  reg [15:0] chen_ff;
  reg [15:0] prescale_value_ff;
  reg [15:0] prescale_active_ff;
  reg [15:0] reload_value_ff;
  reg [15:0] core_count_ff;
  reg [15:0] psc_cnt_ff;
  reg [3:0] channel_flag_ff;
  reg [3:0] channel_overrun_ff;
  reg dir_down_ff;
  reg upd_pend_ff;
  reg [1:0] etr_div_ff;
  reg etr_prev_ff;
  reg ext_trigger_prescaled_ff;
  reg [7:0] cap_div_ff [0:3];
  wire [2:0] slave_mode_select = smcfg_ff[`GTC_SM_SMS_HI:`GTC_SM_SMS_LO];
  wire [2:0] trigger_source_select = smcfg_ff[`GTC_SM_TS_HI:`GTC_SM_TS_LO];
  wire ext_clock2_enable = smcfg_ff[`GTC_SM_ECE];
  wire ext_trigger_invert = smcfg_ff[`GTC_SM_ETP];
  wire [1:0] ext_trigger_divider = smcfg_ff[`GTC_SM_EXT_TRIGGER_DIVIDER_HI:`GTC_SM_EXT_TRIGGER_DIVIDER_LO];
  wire [1:0] cms = ctrl_ff[`GTC_CTRL_CMS_HI:`GTC_CTRL_CMS_LO];
  wire enable = ctrl_ff[`GTC_CTRL_EN];
  // ********************************************************
  // Input filters
  // ********************************************************
  wire [3:0] ti_lvl;
  wire [3:0] ti_rise;
  wire [3:0] ti_fall;
  wire ext_trigger_filtered_rise;
  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_flt
      gtc_filter u_flt (
        .ref_clk(ref_clk),
        .reset(reset),
        .sig_in(chan_pin_in[g]),
        .setting(chcfg_ff[g][7:4]),
        .level_ff(ti_lvl[g]),
        .rise_ff(ti_rise[g]),
        .fall_ff(ti_fall[g])
      );
    end
  endgenerate
  gtc_filter u_etf (
    .ref_clk(ref_clk),
    .reset(reset),
    .sig_in(ext_trigger_prescaled_ff),
    .setting(smcfg_ff[`GTC_SM_ETF_HI:`GTC_SM_ETF_LO]),
    .level_ff(),
    .rise_ff(ext_trigger_filtered_rise),
    .fall_ff()
  );
  // Polarity-selected edge pulse of a channel
  function fp_evt;
    input rise;
    input fall;
    input pol;
    begin
      fp_evt = pol ? fall : rise;
    end
  endfunction
  wire [3:0] pol = {chen_ff[13], chen_ff[9], chen_ff[5], chen_ff[1]};
  wire [3:0] cap_en = {chen_ff[12], chen_ff[8], chen_ff[4], chen_ff[0]};
  wire [3:0] fp;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_fp
      assign fp[g] = fp_evt(ti_rise[g], ti_fall[g], pol[g]);
    end
  endgenerate
  // ********************************************************
  // Clock selection
  // ********************************************************
  reg trigger_input;
  always @* begin
    case (trigger_source_select)
      3'h0, 3'h1, 3'h2, 3'h3: trigger_input = internal_trigger_in[trigger_source_select[1:0]];
      `GTC_TS_ED: trigger_input = ti_rise[0] | ti_fall[0];
      `GTC_TS_FP1: trigger_input = fp[0];
      `GTC_TS_FP2: trigger_input = fp[1];
      default: trigger_input = ext_trigger_filtered_rise;
    endcase
  end
  wire is_enc = (slave_mode_select == `GTC_SMS_ENC1) ||
    (slave_mode_select == `GTC_SMS_ENC2) || (slave_mode_select == `GTC_SMS_ENC3);
  reg psc_in;
  always @* begin
    if (ext_clock2_enable)
      psc_in = ext_trigger_filtered_rise;
    else if (slave_mode_select == `GTC_SMS_EXT1)
      psc_in = trigger_input;
    else if (slave_mode_select == `GTC_SMS_INT)
      psc_in = 1'b1;
    else
      psc_in = 1'b0;
  end
  // encoder edges, qualified by the other channel's level
  wire enc_a = (slave_mode_select != `GTC_SMS_ENC1) & (ti_rise[0] | ti_fall[0]);
  wire enc_b = (slave_mode_select != `GTC_SMS_ENC2) & (ti_rise[1] | ti_fall[1]);
  wire enc_tick = is_enc & ~ext_clock2_enable & (enc_a | enc_b);
  wire enc_down = enc_a ? (ti_lvl[0] == ti_lvl[1]) : (ti_lvl[0] != ti_lvl[1]);
  // ********************************************************
  // Prescaler and counter
  // ********************************************************
  wire sw_ug = wr_stb && (addr == `GTC_OFF_EVGEN) && wdata[`GTC_EV_UG];
  wire psc_tick_in = enable & psc_in;
  wire counter_tick = psc_tick_in && (psc_cnt_ff == prescale_active_ff);
  wire cnt_wr = wr_stb && (addr == `GTC_OFF_COUNT);
  wire step = enc_tick | counter_tick;
  wire going_down = is_enc ? enc_down : dir_down_ff;
  wire at_end = going_down ? (core_count_ff == 16'h0000) :
    (core_count_ff == reload_value_ff);
  wire ovf = enable & step & at_end;
  wire update = sw_ug | upd_pend_ff | (ovf && (cms == 2'h0 || is_enc));
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      psc_cnt_ff <= `GTC_RST_ZERO;
      prescale_active_ff <= `GTC_RST_ZERO;
      core_count_ff <= `GTC_RST_ZERO;
      dir_down_ff <= 1'b0;
      upd_pend_ff <= 1'b1;
      update_evt_ff <= 1'b0;
    end else begin
      upd_pend_ff <= 1'b0;
      update_evt_ff <= update;
      if (update) begin
        prescale_active_ff <= prescale_value_ff;
        psc_cnt_ff <= `GTC_RST_ZERO;
      end else if (psc_tick_in)
        psc_cnt_ff <= counter_tick ? `GTC_RST_ZERO : psc_cnt_ff + 16'h0001;
      if (cnt_wr)
        core_count_ff <= wdata;
      else if (sw_ug)
        core_count_ff <= dir_down_ff ? reload_value_ff : `GTC_RST_ZERO;
      else if (enable && step) begin
        if (at_end && cms == 2'h0 && !is_enc)
          core_count_ff <= going_down ? reload_value_ff : `GTC_RST_ZERO;
        else if (at_end && cms != 2'h0 && !is_enc) begin
          dir_down_ff <= ~dir_down_ff;
          core_count_ff <= going_down ? core_count_ff + 16'h0001 :
            core_count_ff - 16'h0001;
        end else if (at_end)
          core_count_ff <= going_down ? reload_value_ff : `GTC_RST_ZERO;
        else
          core_count_ff <= going_down ? core_count_ff - 16'h0001 :
            core_count_ff + 16'h0001;
      end
      if (cms == 2'h0 && wr_stb && addr == `GTC_OFF_CTRL)
        dir_down_ff <= wdata[`GTC_CTRL_DIR];
    end
  end
  // ********************************************************
  // External trigger conditioning
  // ********************************************************
  wire etr_pol = ext_trigger_pin ^ ext_trigger_invert;
  wire etr_edge = etr_pol & ~etr_prev_ff;
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      etr_prev_ff <= 1'b0;
      etr_div_ff <= 2'h0;
      ext_trigger_prescaled_ff <= 1'b0;
    end else begin
      etr_prev_ff <= etr_pol;
      // Divide by 1, 2, 4 or 8 via edge counting
      if (ext_trigger_divider == 2'h0)
        ext_trigger_prescaled_ff <= etr_pol;
      else if (etr_edge) begin
        etr_div_ff <= etr_div_ff + 2'h1;
        if ((etr_div_ff & ((2'h1 << (ext_trigger_divider - 2'h1)) - 2'h1)) == 2'h0)
          ext_trigger_prescaled_ff <= ~ext_trigger_prescaled_ff;
      end
    end
  end
  // ********************************************************
  // Capture/compare channels
  // ********************************************************
  wire [15:0] pre [0:3];
  wire [15:0] shd [0:3];
  wire [3:0] cap_evt;
  wire [3:0] is_cap;
  wire [3:0] cmp_hit;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_ch
      wire [1:0] sel = chcfg_ff[g][1:0];
      wire nb = fp[g ^ 1];
      wire ic = (sel == 2'h1) ? fp[g] : nb;
      wire [1:0] capture_prescale = chcfg_ff[g][3:2];
      assign is_cap[g] = (sel != 2'h0);
      assign cap_evt[g] = (is_cap[g] && cap_en[g] && ic &&
        ((cap_div_ff[g] & ((8'h1 << capture_prescale) - 8'h1)) == 8'h0)) ||
        (wr_stb && addr == `GTC_OFF_EVGEN && wdata[`GTC_EV_CC0 + g] && is_cap[g]);
      assign cmp_hit[g] = !is_cap[g] && step && enable && (core_count_ff == shd[g]);
      always @(posedge ref_clk or posedge reset) begin
        if (reset)
          cap_div_ff[g] <= 8'h00;
        else if (!is_cap[g])
          cap_div_ff[g] <= 8'h00;
        else if (ic && cap_en[g])
          cap_div_ff[g] <= cap_div_ff[g] + 8'h01;
      end
      gtc_ccreg u_cc (
        .ref_clk(ref_clk),
        .reset(reset),
        .is_capture(is_cap[g]),
        .preload_en(chcfg_ff[g][3]),
        .update(update),
        .sw_we(wr_stb && addr == (`GTC_OFF_CMP0 + 8'h04 * g)),
        .sw_wdata(wdata),
        .cap_evt(cap_evt[g]),
        .count(core_count_ff),
        .preload_ff(pre[g]),
        .shadow_ff(shd[g])
      );
    end
  endgenerate
  // ********************************************************
  // Register writes, flags and outputs
  // ********************************************************
  integer i;
  integer k;
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_ff <= `GTC_RST_ZERO;
      smcfg_ff <= `GTC_RST_ZERO;
      chen_ff <= `GTC_RST_ZERO;
      prescale_value_ff <= `GTC_RST_ZERO;
      reload_value_ff <= `GTC_RST_RELOAD;
      channel_flag_ff <= 4'h0;
      channel_overrun_ff <= 4'h0;
      for (i = 0; i < 4; i = i + 1)
        chcfg_ff[i] <= `GTC_RST_ZERO;
    end else begin
      if (wr_stb) begin
        case (addr)
          `GTC_OFF_CTRL: ctrl_ff <= wdata;
          `GTC_OFF_SMCFG: smcfg_ff <= wdata;
          `GTC_OFF_CHCFG: begin
            chcfg_ff[0] <= {8'h00, wdata[7:0]};
            chcfg_ff[1] <= {8'h00, wdata[15:8]};
          end
          `GTC_OFF_CHCFG + 8'h04: begin
            chcfg_ff[2] <= {8'h00, wdata[7:0]};
            chcfg_ff[3] <= {8'h00, wdata[15:8]};
          end
          `GTC_OFF_CHEN: chen_ff <= wdata;
          `GTC_OFF_PRESCALE: prescale_value_ff <= wdata;
          `GTC_OFF_RELOAD: reload_value_ff <= wdata;
          default: ;
        endcase
      end
      // Write 0 clears a flag; a new event the same cycle wins
      for (i = 0; i < 4; i = i + 1) begin
        if (cap_evt[i] || cmp_hit[i])
          channel_flag_ff[i] <= 1'b1;
        else if (wr_stb && addr == `GTC_OFF_STATUS && !wdata[i])
          channel_flag_ff[i] <= 1'b0;
        else if (rd_stb && addr == (`GTC_OFF_CMP0 + 8'h04 * i) && is_cap[i])
          channel_flag_ff[i] <= 1'b0;
        if (cap_evt[i] && channel_flag_ff[i])
          channel_overrun_ff[i] <= 1'b1;
        else if (wr_stb && addr == `GTC_OFF_STATUS && !wdata[8 + i])
          channel_overrun_ff[i] <= 1'b0;
      end
    end
  end
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdata_ff <= `GTC_RST_ZERO;
      trigger_output_ff <= 1'b0;
      chan_pin_out_ff <= 4'h0;
      chan_pin_oe_n_ff <= 4'hf;
    end else begin
      trigger_output_ff <= psc_tick_in;
      for (k = 0; k < 4; k = k + 1) begin
        chan_pin_oe_n_ff[k] <= is_cap[k] | ~cap_en[k];
        if (cmp_hit[k])
          chan_pin_out_ff[k] <= ~chan_pin_out_ff[k];
      end
      rdata_ff <= `GTC_RST_ZERO;
      if (rd_stb) begin
        case (addr)
          `GTC_OFF_CTRL: rdata_ff <= {ctrl_ff[15:5], dir_down_ff, ctrl_ff[3:0]};
          `GTC_OFF_SMCFG: rdata_ff <= smcfg_ff;
          `GTC_OFF_STATUS: rdata_ff <= {4'h0, channel_overrun_ff, 4'h0, channel_flag_ff};
          `GTC_OFF_CHCFG: rdata_ff <= {chcfg_ff[1][7:0], chcfg_ff[0][7:0]};
          `GTC_OFF_CHCFG + 8'h04: rdata_ff <= {chcfg_ff[3][7:0], chcfg_ff[2][7:0]};
          `GTC_OFF_CHEN: rdata_ff <= chen_ff;
          `GTC_OFF_COUNT: rdata_ff <= core_count_ff;
          `GTC_OFF_PRESCALE: rdata_ff <= prescale_value_ff;
          `GTC_OFF_RELOAD: rdata_ff <= reload_value_ff;
          `GTC_OFF_CMP0: rdata_ff <= pre[0];
          `GTC_OFF_CMP0 + 8'h04: rdata_ff <= pre[1];
          `GTC_OFF_CMP0 + 8'h08: rdata_ff <= pre[2];
          `GTC_OFF_CMP0 + 8'h0c: rdata_ff <= pre[3];
          default: rdata_ff <= `GTC_RST_ZERO;
        endcase
      end
    end
  end
endmodule

// file: gtc_far_end.sv
// Far-side model: trigger pin, sibling timer triggers and channel pin sources
`timescale 1ns/1ps
module gtc_far_end (
  // Clock
  input wire ref_clk,
  // Lines toward the timer
  output reg ext_trigger_pin,
  output reg [3:0] internal_trigger_in,
  output reg [3:0] chan_drv
);
  // ****************************************
  // Pulse sources
  // ****************************************
  initial begin
    ext_trigger_pin = 1'b0;
    internal_trigger_in = 4'h0;
    chan_drv = 4'h0;
  end
  // One-clock trigger pulses, spaced four clocks
  task itr_pulses(input [3:0] m, input integer n);
    integer j;
    begin
      for (j = 0; j < n; j = j + 1) begin
        internal_trigger_in <= m;
        @(posedge ref_clk);
        internal_trigger_in <= 4'h0;
        repeat (3) @(posedge ref_clk);
      end
    end
  endtask
  // Pin pulses long enough to pass the filter
  task ext_pulses(input integer n);
    integer j;
    begin
      for (j = 0; j < n; j = j + 1) begin
        ext_trigger_pin <= 1'b1;
        repeat (4) @(posedge ref_clk);
        ext_trigger_pin <= 1'b0;
        repeat (4) @(posedge ref_clk);
      end
    end
  endtask
  task chan_level(input integer k, input v);
    begin
      chan_drv[k] <= v;
      repeat (6) @(posedge ref_clk);
    end
  endtask
endmodule

// file: gtc_timer_chk.sv
// Port-level assertions for the timer core
`timescale 1ns/1ps
`include "gtc_consts.vh"
module gtc_timer_chk #(
  parameter NCH = 4
) (
  // Clock and reset
  input wire ref_clk,
  input wire reset,
  // Register port
  input wire [7:0] addr,
  input wire [15:0] wdata,
  input wire wr_stb,
  input wire rd_stb,
  input wire [15:0] rdata_ff,
  // Pins and events
  input wire ext_trigger_pin,
  input wire [3:0] internal_trigger_in,
  input wire [3:0] chan_pin_in,
  input wire [3:0] chan_pin_out_ff,
  input wire [3:0] chan_pin_oe_n_ff,
  input wire trigger_output_ff,
  input wire update_evt_ff
);
  // ****************************************
  // Shadow of written settings
  // ****************************************
  reg [15:0] ctrl_ff, smcfg_ff, rel_ff, chen_ff, chcfg_ff;
  always @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ctrl_ff <= 16'h0000;
      smcfg_ff <= 16'h0000;
      rel_ff <= 16'hffff;
      chen_ff <= 16'h0000;
      chcfg_ff <= 16'h0000;
    end else if (wr_stb) begin
      case (addr)
        `GTC_OFF_CTRL: ctrl_ff <= wdata;
        `GTC_OFF_SMCFG: smcfg_ff <= wdata;
        `GTC_OFF_RELOAD: rel_ff <= wdata;
        `GTC_OFF_CHEN: chen_ff <= wdata;
        `GTC_OFF_CHCFG: chcfg_ff <= wdata;
        default: ;
      endcase
    end
  end
  wire en = ctrl_ff[`GTC_CTRL_EN] && !smcfg_ff[`GTC_SM_ECE];
  wire int_clk = en && smcfg_ff[2:0] == `GTC_SMS_INT;
  wire ext1_t0 = en && smcfg_ff[2:0] == `GTC_SMS_EXT1 && smcfg_ff[6:4] == 3'h0;
  wire ch0_cmp = chen_ff[0] && chcfg_ff[1:0] == 2'b00;
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  sequence s_ug;
    wr_stb && addr == `GTC_OFF_EVGEN && wdata[`GTC_EV_UG];
  endsequence
  sequence s_itr0;
    ext1_t0 [*4] ##0 internal_trigger_in[0];
  endsequence
  a_rd_idle_zero: assert property (!rd_stb |=> rdata_ff == 16'h0000)
    else $error("read data not zero outside read slot");
  a_rd_unmapped: assert property (rd_stb && (addr == 8'h30 || addr > 8'h40) |=> !rdata_ff)
    else $error("unmapped read not zero");
  a_reload_back: assert property (rd_stb && addr == `GTC_OFF_RELOAD |=> rdata_ff == $past(rel_ff))
    else $error("reload readback wrong");
  a_reset_update: assert property ($fell(reset) |-> ##[0:2] update_evt_ff)
    else $error("no update after reset");
  a_force_update: assert property (s_ug |-> ##[1:2] update_evt_ff)
    else $error("no update after force");
  a_int_clk_out: assert property (int_clk [*3] |-> trigger_output_ff)
    else $error("bus clock not on trigger output");
  a_ext1_itr_out: assert property (s_itr0 |-> ##[1:3] trigger_output_ff)
    else $error("internal trigger not passed");
  a_oe_compare: assert property (!chan_pin_oe_n_ff[0] |-> ch0_cmp || $past(ch0_cmp))
    else $error("pin driven outside compare");
endmodule
bind gtc_timer gtc_timer_chk #(.NCH(NCH)) i_gtc_timer_chk (.ref_clk(ref_clk), .reset(reset),
  .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_ff(rdata_ff),
  .ext_trigger_pin(ext_trigger_pin), .internal_trigger_in(internal_trigger_in),
  .chan_pin_in(chan_pin_in), .chan_pin_out_ff(chan_pin_out_ff),
  .chan_pin_oe_n_ff(chan_pin_oe_n_ff), .trigger_output_ff(trigger_output_ff),
  .update_evt_ff(update_evt_ff));

// file: testbench.sv
// Self-checking testbench for the timer core
`timescale 1ns/1ps
`include "gtc_consts.vh"
`define CHK(g, e) begin check_count = check_count + 1; if ((g) !== (e)) begin \
  err_count = err_count + 1; $display("CHECK FAILED %0t got %h want %h", $time, g, e); end end
module testbench;
  reg ref_clk, reset, wr_stb, rd_stb, pb;
  reg [7:0] addr, a;
  reg [15:0] wdata, v, mx, pv;
  reg [31:0] seed;
  reg [15:0] bq [0:63];
  integer err_count, check_count, i, j, per;
  wire [15:0] rdata_ff;
  wire ext_trigger_pin, trigger_output_ff, update_evt_ff;
  wire [3:0] internal_trigger_in, chan_drv, chan_pin_out_ff, chan_pin_oe_n_ff, chan_wire;
  // Pin level seen by both sides
  assign chan_wire = (chan_pin_oe_n_ff & chan_drv) | (~chan_pin_oe_n_ff & chan_pin_out_ff);
  gtc_timer #(.NCH(4)) i_gtc_timer (.ref_clk(ref_clk), .reset(reset), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata_ff(rdata_ff),
    .ext_trigger_pin(ext_trigger_pin), .internal_trigger_in(internal_trigger_in),
    .chan_pin_in(chan_wire), .chan_pin_out_ff(chan_pin_out_ff),
    .chan_pin_oe_n_ff(chan_pin_oe_n_ff), .trigger_output_ff(trigger_output_ff),
    .update_evt_ff(update_evt_ff));
  gtc_far_end i_gtc_far_end (.ref_clk(ref_clk), .ext_trigger_pin(ext_trigger_pin),
    .internal_trigger_in(internal_trigger_in), .chan_drv(chan_drv));
  // ****************************************
  // Helpers
  // ****************************************
  function [31:0] xs(input [31:0] s);
    reg [31:0] t;
    begin
      t = s ^ (s << 13);
      t = t ^ (t >> 17);
      xs = t ^ (t << 5);
    end
  endfunction
  function [15:0] step(input dn, input [15:0] n);
    step = dn ? 16'h0000 - n : n;
  endfunction
  function integer period(input integer m, input [15:0] r);
    period = (m == 2) ? 2 * r : r + 1;
  endfunction
  // Clock source per case: triggers 0..3, mode 1 on pin, mode 2 plain, inverted, halved
  function [15:0] sm_cfg(input integer k);
    case (k)
      4: sm_cfg = 16'h0077;
      5: sm_cfg = 16'h4000;
      6: sm_cfg = 16'hc000;
      7: sm_cfg = 16'h5000;
      default: sm_cfg = {9'h000, k[2:0], 4'h7};
    endcase
  endfunction
  task wr(input [7:0] ad, input [15:0] d);
    begin
      addr <= ad;
      wdata <= d;
      wr_stb <= 1'b1;
      @(posedge ref_clk);
      wr_stb <= 1'b0;
      @(posedge ref_clk);
    end
  endtask
  // Back-to-back reads of one address into bq
  task rd(input [7:0] ad, input integer n);
    integer k;
    begin
      addr <= ad;
      rd_stb <= 1'b1;
      for (k = 0; k < n; k = k + 1) begin
        @(posedge ref_clk);
        if (k == n - 1) rd_stb <= 1'b0;
        #1 bq[k] = rdata_ff;
      end
      @(posedge ref_clk);
    end
  endtask
  task setup(input [15:0] c, input [15:0] s, input [15:0] p, input [15:0] r, input [15:0] n);
    begin
      wr(`GTC_OFF_CTRL, 16'h0000);
      wr(`GTC_OFF_SMCFG, s);
      wr(`GTC_OFF_PRESCALE, p);
      wr(`GTC_OFF_RELOAD, r);
      wr(`GTC_OFF_EVGEN, 16'h0001);
      wr(`GTC_OFF_COUNT, n);
      wr(`GTC_OFF_CTRL, c);
    end
  endtask
  task give_verdict;
    begin
      $display("errors %0d checks %0d", err_count, check_count);
      if (err_count == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
    end
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  initial begin
    repeat (30000) @(posedge ref_clk);
    err_count = err_count + 1;
    give_verdict;
  end
  initial begin
    reset = 1'b1;
    wr_stb = 1'b0;
    rd_stb = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    err_count = 0;
    check_count = 0;
    seed = 32'h33834704;
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    @(posedge ref_clk);
    rd(`GTC_OFF_RELOAD, 1);
    `CHK(bq[0], 16'hffff);
    rd(`GTC_OFF_COUNT, 1);
    `CHK(bq[0], 16'h0000);
    wr(8'h44, 16'h1234);
    rd(8'h44, 1);
    `CHK(bq[0], 16'h0000);
    for (i = 0; i < 6; i = i + 1) begin
      seed = xs(seed);
      a = 8'h28 + 8'h04 * i[7:0] + ((i > 1) ? 8'h04 : 8'h00);
      wr(a, seed[15:0]);
      rd(a, 1);
      `CHK(bq[0], seed[15:0]);
    end
    for (i = 0; i < 4; i = i + 1) begin
      seed = xs(seed);
      pv = {13'h0000, seed[2:0]};
      setup(i[0] ? 16'h0011 : 16'h0001, 16'h0000, pv, 16'hffff, 16'h8000);
      rd(`GTC_OFF_COUNT, 4 * (pv + 1) + 1);
      v = bq[4 * (pv + 1)] - bq[0];
      `CHK(v, step(i[0], 16'h0004));
      wr(`GTC_OFF_PRESCALE, pv + 16'h0001);
      rd(`GTC_OFF_COUNT, 4 * (pv + 1) + 1);
      v = bq[4 * (pv + 1)] - bq[0];
      `CHK(v, step(i[0], 16'h0004));
      wr(`GTC_OFF_EVGEN, 16'h0001);
      rd(`GTC_OFF_COUNT, 4 * (pv + 2) + 1);
      v = bq[4 * (pv + 2)] - bq[0];
      `CHK(v, step(i[0], 16'h0004));
    end
    for (i = 0; i < 3; i = i + 1) begin
      seed = xs(seed);
      v = {14'h0000, seed[1:0]} + 16'h0004;
      per = period(i, v);
      setup((i == 2) ? 16'h0021 : (i == 1) ? 16'h0011 : 16'h0001, 16'h0000, 16'h0000, v, 16'h0000);
      rd(`GTC_OFF_COUNT, 2 * per);
      mx = 16'h0000;
      for (j = 0; j < per; j = j + 1) begin
        if (bq[j] > mx) mx = bq[j];
        `CHK(bq[j + per], bq[j]);
      end
      `CHK(mx, v);
    end
    for (i = 0; i < 8; i = i + 1) begin
      setup(16'h0001, sm_cfg(i), 16'h0000, 16'hffff, 16'h0000);
      if (i < 4) begin
        i_gtc_far_end.itr_pulses(4'h1 << i, 4);
        i_gtc_far_end.itr_pulses(4'h1 << ((i + 1) % 4), 3);
      end else begin
        i_gtc_far_end.ext_pulses(4);
      end
      repeat (6) @(posedge ref_clk);
      rd(`GTC_OFF_COUNT, 1);
      `CHK(bq[0], (i == 7) ? 16'h0002 : 16'h0004);
    end
    // Encoder: one quadrature cycle, four steps up
    setup(16'h0001, 16'h0003, 16'h0000, 16'hffff, 16'h0010);
    for (i = 0; i < 4; i = i + 1)
      i_gtc_far_end.chan_level(i % 2, ~i[1]);
    rd(`GTC_OFF_COUNT, 1);
    `CHK(bq[0], 16'h0014);
    // Unused channels in capture mode, disabled, so no compare flags
    setup(16'h0001, 16'h0000, 16'h0000, 16'hffff, 16'h0000);
    wr(`GTC_OFF_CHCFG + 8'h04, 16'h0101);
    wr(`GTC_OFF_STATUS, 16'h0000);
    wr(`GTC_OFF_CHCFG, 16'h0101);
    wr(`GTC_OFF_CHEN, 16'h0001);
    rd(`GTC_OFF_COUNT, 1);
    mx = bq[0];
    i_gtc_far_end.chan_level(0, 1'b1);
    rd(`GTC_OFF_STATUS, 1);
    `CHK(bq[0], 16'h0001);
    i_gtc_far_end.chan_level(0, 1'b0);
    i_gtc_far_end.chan_level(0, 1'b1);
    rd(`GTC_OFF_STATUS, 1);
    `CHK(bq[0], 16'h0101);
    rd(`GTC_OFF_CMP0, 1);
    v = bq[0] - mx;
    `CHK(v > 16'h0004 && v < 16'h0040, 1'b1);
    wr(`GTC_OFF_CHEN, 16'h0003);
    wr(`GTC_OFF_STATUS, 16'h0000);
    i_gtc_far_end.chan_level(0, 1'b0);
    rd(`GTC_OFF_STATUS, 1);
    `CHK(bq[0], 16'h0001);
    wr(`GTC_OFF_STATUS, 16'h0000);
    i_gtc_far_end.chan_level(0, 1'b1);
    rd(`GTC_OFF_STATUS, 1);
    `CHK(bq[0], 16'h0000);
    wr(`GTC_OFF_CHCFG, 16'h0102);
    wr(`GTC_OFF_CHEN, 16'h0001);
    i_gtc_far_end.chan_level(1, 1'b1);
    rd(`GTC_OFF_STATUS, 1);
    `CHK(bq[0], 16'h0001);
    setup(16'h0001, 16'h0000, 16'h0000, 16'h0013, 16'h0000);
    wr(`GTC_OFF_CHCFG, 16'h0000);
    seed = xs(seed);
    wr(`GTC_OFF_CMP0, {12'h000, seed[3:0]} + 16'h0001);
    wr(`GTC_OFF_CHEN, 16'h0001);
    #1;
    `CHK(chan_pin_oe_n_ff[0], 1'b0);
    pb = chan_pin_out_ff[0];
    j = 0;
    for (i = 0; i < 40; i = i + 1) begin
      @(posedge ref_clk);
      #1 if (chan_pin_out_ff[0] !== pb) j = j + 1;
      pb = chan_pin_out_ff[0];
    end
    `CHK(j, 2);
    give_verdict;
  end
endmodule
